/* ocpll_pkg.sv */
/*
 * ocpll_pkg: register map, field layout, reset values and carrier types
 * for the oscillator and dual synthesiser control block.
 * assumes an APB master with 32-bit data; offsets are register indexes.
 */
package ocpll_pkg;

  // printed offsets are indexes; byte address is four times the index
  localparam logic [7:0] IDX_A_FRAC_LOW  = 8'h00;
  localparam logic [7:0] IDX_A_FRAC_MID  = 8'h01;
  localparam logic [7:0] IDX_A_FRAC_HIGH = 8'h02;
  localparam logic [7:0] IDX_A_DIVIDERS  = 8'h03;
  localparam logic [7:0] IDX_B_FRAC_LOW  = 8'h04;
  localparam logic [7:0] IDX_B_FRAC_MID  = 8'h05;
  localparam logic [7:0] IDX_B_FRAC_HIGH = 8'h06;
  localparam logic [7:0] IDX_B_DIVIDERS  = 8'h07;
  localparam logic [7:0] IDX_POWER_DOWN  = 8'h33;
  localparam logic [7:0] IDX_STATUS      = 8'h40;

  // field positions
  localparam int FRAC_HIGH_LSB  = 0;
  localparam int INT_MULT_LSB   = 4;
  localparam int INPUT_DIV_BIT  = 0;
  localparam int OUT_EXTRA_BIT  = 1;
  localparam int OUT_MODE_LSB   = 3;
  localparam int OSC_PD_BIT     = 0;
  localparam int SYNTH_A_PD_BIT = 1;
  localparam int SYNTH_B_PD_BIT = 2;

  // reset values
  localparam logic [8:0] RST_A_FRAC_LOW  = 9'h121;
  localparam logic [8:0] RST_A_FRAC_MID  = 9'h17D;
  localparam logic [8:0] RST_B_FRAC_LOW  = 9'h121;
  localparam logic [8:0] RST_B_FRAC_MID  = 9'h17E;
  localparam logic [3:0] RST_FRAC_HIGH   = 4'hD;
  localparam logic [3:0] RST_INT_MULT    = 4'h7;
  localparam logic       RST_INPUT_DIV   = 1'b0;
  localparam logic [1:0] RST_OUT_MODE    = 2'h2;
  localparam logic       RST_OUT_EXTRA   = 1'b0;
  localparam logic       RST_OSC_PD      = 1'b0;
  localparam logic       RST_SYNTH_PD    = 1'b1;

  // one synthesiser's settings as seen by the analogue loop
  typedef struct packed {
    logic [21:0] fracMult;
    logic [3:0]  intMult;
    logic        inputDiv;
    logic [1:0]  outDivMode;
    logic        outDivExtra;
  } ocpll_synth_s;

  // APB answer carrier
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ocpll_apb_rsp_s;

  typedef enum logic [2:0] {
    ST_USER    = 3'b001,
    ST_TRACK   = 3'b010,
    ST_LOCKED  = 3'b100
  } ocpll_mode_e;

endpackage : ocpll_pkg

/* ocpll_ctrl.sv */
/*
 * ocpll_ctrl: control registers and mode logic for the oscillator output
 * stage and two fractional-N synthesisers.
 * assumes receiver signals arrive on sys_clk; APB slave with zero waits.
 */
// Contract
// - oscillator clock feeds both synthesisers and pins
// - oscillator stage power-down bit zero
// - synthesiser power-down bits one and two
// - receiver enabled selects receive mode
// - receiver drives synthesiser A in receive mode
// - A core clock held at 256fs
// - A output usable at 256fs or 128fs
// - A output stopped while tracking until receiver locks; kept running on stream loss
// - stream loss freezes A multipliers
// - user mode takes all settings from registers
// - 22-bit fraction split over three registers
// - integer multiplier bits 7:4, reset 0111
// - A post-scale 0 gives 256fs, 1 128fs
`timescale 1ns/1ns
module ocpll_ctrl (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output ocpll_pkg::ocpll_apb_rsp_s  apbRsp,
  input  wire logic                  rxEnable,
  input  wire logic                  rxLocked,
  input  wire logic                  rxStreamPresent,
  input  wire logic [21:0]           rxFracMult,
  input  wire logic [3:0]            rxIntMult,
  output logic                       oscOutPowerDown,
  output logic                       synthAPowerDown,
  output logic                       synthBPowerDown,
  output ocpll_pkg::ocpll_synth_s    synthA,
  output ocpll_pkg::ocpll_synth_s    synthB,
  output logic                       synthAOutEnable,
  output logic                       synthBOutAvailable,
  output logic                       receiveMode,
  output logic                       oscRefEnable
);

  // receiver's fixed output divider choice giving a 256fs core clock
  localparam logic [1:0] RX_CORE_MODE = 2'h2;

  typedef struct packed {
    logic [21:0]               aFrac;
    logic [3:0]                aInt;
    logic                      aInDiv;
    logic [1:0]                aMode;
    logic                      aExtra;
    logic [21:0]               bFrac;
    logic [3:0]                bInt;
    logic                      bInDiv;
    logic [1:0]                bMode;
    logic                      bExtra;
    logic                      osc_out_power_down;
    logic                      aPd;
    logic                      bPd;
    logic [21:0]               frozenFrac;
    logic [3:0]                frozenInt;
    ocpll_pkg::ocpll_mode_e    mode;
    logic [31:0]               rdata;
  } ocpll_state_s;

  ocpll_state_s state_ff;
  ocpll_state_s nxt_state;

  // word index decode from byte address, used for both read and write
  function automatic logic is_reg(input logic [11:0] addr,
                                  input logic [7:0]  idx);
    is_reg = (addr[1:0] == 2'h0) && (addr[11:2] == {2'h0, idx});
  endfunction : is_reg

  logic        setupRd;
  logic        accessWr;
  logic [8:0]  wd;
  logic [31:0] rdMux;

  assign setupRd  = psel && !penable && !pwrite;
  assign accessWr = psel && penable && pwrite;
  assign wd       = pwdata[8:0]; // only nine bits are ever stored

  // read mux; unmapped words read zero, reserved bits zero
  always_comb
  begin
    rdMux = 32'h0000_0000;
    if (is_reg(paddr, ocpll_pkg::IDX_A_FRAC_LOW))
      rdMux[8:0] = state_ff.aFrac[8:0];
    else if (is_reg(paddr, ocpll_pkg::IDX_A_FRAC_MID))
      rdMux[8:0] = state_ff.aFrac[17:9];
    else if (is_reg(paddr, ocpll_pkg::IDX_A_FRAC_HIGH))
      rdMux[7:0] = {state_ff.aInt, state_ff.aFrac[21:18]};
    else if (is_reg(paddr, ocpll_pkg::IDX_A_DIVIDERS))
      rdMux[4:0] = {state_ff.aMode, 1'b0, state_ff.aExtra,
                    state_ff.aInDiv};
    else if (is_reg(paddr, ocpll_pkg::IDX_B_FRAC_LOW))
      rdMux[8:0] = state_ff.bFrac[8:0];
    else if (is_reg(paddr, ocpll_pkg::IDX_B_FRAC_MID))
      rdMux[8:0] = state_ff.bFrac[17:9];
    else if (is_reg(paddr, ocpll_pkg::IDX_B_FRAC_HIGH))
      rdMux[7:0] = {state_ff.bInt, state_ff.bFrac[21:18]};
    else if (is_reg(paddr, ocpll_pkg::IDX_B_DIVIDERS))
      rdMux[4:0] = {state_ff.bMode, 1'b0, state_ff.bExtra,
                    state_ff.bInDiv};
    else if (is_reg(paddr, ocpll_pkg::IDX_POWER_DOWN))
      rdMux[2:0] = {state_ff.bPd, state_ff.aPd, state_ff.osc_out_power_down};
    else if (is_reg(paddr, ocpll_pkg::IDX_STATUS))
      rdMux[4:0] = {synthAOutEnable, synthBOutAvailable,
                    state_ff.mode == ocpll_pkg::ST_LOCKED,
                    state_ff.mode == ocpll_pkg::ST_TRACK, receiveMode};
  end

  // register writes, mode sequencing and freeze capture
  always_comb
  begin
    nxt_state = state_ff;
    if (setupRd)
      nxt_state.rdata = rdMux;
    if (accessWr)
    begin
      if (is_reg(paddr, ocpll_pkg::IDX_A_FRAC_LOW))
        nxt_state.aFrac[8:0] = wd;
      if (is_reg(paddr, ocpll_pkg::IDX_A_FRAC_MID))
        nxt_state.aFrac[17:9] = wd;
      if (is_reg(paddr, ocpll_pkg::IDX_A_FRAC_HIGH))
      begin
        nxt_state.aFrac[21:18] = wd[ocpll_pkg::FRAC_HIGH_LSB +: 4];
        nxt_state.aInt = wd[ocpll_pkg::INT_MULT_LSB +: 4];
      end
      if (is_reg(paddr, ocpll_pkg::IDX_A_DIVIDERS))
      begin
        nxt_state.aInDiv = wd[ocpll_pkg::INPUT_DIV_BIT];
        nxt_state.aExtra = wd[ocpll_pkg::OUT_EXTRA_BIT];
        nxt_state.aMode  = wd[ocpll_pkg::OUT_MODE_LSB +: 2];
      end
      if (is_reg(paddr, ocpll_pkg::IDX_B_FRAC_LOW))
        nxt_state.bFrac[8:0] = wd;
      if (is_reg(paddr, ocpll_pkg::IDX_B_FRAC_MID))
        nxt_state.bFrac[17:9] = wd;
      if (is_reg(paddr, ocpll_pkg::IDX_B_FRAC_HIGH))
      begin
        nxt_state.bFrac[21:18] = wd[ocpll_pkg::FRAC_HIGH_LSB +: 4];
        nxt_state.bInt = wd[ocpll_pkg::INT_MULT_LSB +: 4];
      end
      if (is_reg(paddr, ocpll_pkg::IDX_B_DIVIDERS))
      begin
        nxt_state.bInDiv = wd[ocpll_pkg::INPUT_DIV_BIT];
        nxt_state.bExtra = wd[ocpll_pkg::OUT_EXTRA_BIT];
        nxt_state.bMode  = wd[ocpll_pkg::OUT_MODE_LSB +: 2];
      end
      if (is_reg(paddr, ocpll_pkg::IDX_POWER_DOWN))
      begin
        nxt_state.osc_out_power_down = wd[ocpll_pkg::OSC_PD_BIT];
        nxt_state.aPd   = wd[ocpll_pkg::SYNTH_A_PD_BIT];
        nxt_state.bPd   = wd[ocpll_pkg::SYNTH_B_PD_BIT];
      end
    end
    // receiver values tracked while stream present, held when it stops
    if (rxEnable && rxStreamPresent)
    begin
      nxt_state.frozenFrac = rxFracMult;
      nxt_state.frozenInt  = rxIntMult;
    end
    // mode: track until lock; lock loss with stream means a retrack
    case (state_ff.mode)
      ocpll_pkg::ST_USER:
        if (rxEnable)
          nxt_state.mode = ocpll_pkg::ST_TRACK;
      ocpll_pkg::ST_TRACK:
        if (!rxEnable)
          nxt_state.mode = ocpll_pkg::ST_USER;
        else if (rxLocked)
          nxt_state.mode = ocpll_pkg::ST_LOCKED;
      ocpll_pkg::ST_LOCKED:
        if (!rxEnable)
          nxt_state.mode = ocpll_pkg::ST_USER;
        else if (!rxLocked && rxStreamPresent)
          nxt_state.mode = ocpll_pkg::ST_TRACK;
      default:
        nxt_state.mode = ocpll_pkg::ST_USER;
    endcase
  end

  // single register stage; reset values restore documented defaults
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_ff.aFrac  <= {ocpll_pkg::RST_FRAC_HIGH,
                          ocpll_pkg::RST_A_FRAC_MID,
                          ocpll_pkg::RST_A_FRAC_LOW};
      state_ff.aInt   <= ocpll_pkg::RST_INT_MULT;
      state_ff.aInDiv <= ocpll_pkg::RST_INPUT_DIV;
      state_ff.aMode  <= ocpll_pkg::RST_OUT_MODE;
      state_ff.aExtra <= ocpll_pkg::RST_OUT_EXTRA;
      state_ff.bFrac  <= {ocpll_pkg::RST_FRAC_HIGH,
                          ocpll_pkg::RST_B_FRAC_MID,
                          ocpll_pkg::RST_B_FRAC_LOW};
      state_ff.bInt   <= ocpll_pkg::RST_INT_MULT;
      state_ff.bInDiv <= ocpll_pkg::RST_INPUT_DIV;
      state_ff.bMode  <= ocpll_pkg::RST_OUT_MODE;
      state_ff.bExtra <= ocpll_pkg::RST_OUT_EXTRA;
      state_ff.osc_out_power_down  <= ocpll_pkg::RST_OSC_PD;
      state_ff.aPd    <= ocpll_pkg::RST_SYNTH_PD;
      state_ff.bPd    <= ocpll_pkg::RST_SYNTH_PD;
      state_ff.frozenFrac <= 22'h00_0000;
      state_ff.frozenInt  <= ocpll_pkg::RST_INT_MULT;
      state_ff.mode   <= ocpll_pkg::ST_USER;
      state_ff.rdata  <= 32'h0000_0000;
    end
    else
      state_ff <= nxt_state;
  end

  // apb answer: zero wait states, no error for unmapped words
  assign apbRsp.prdata  = state_ff.rdata;
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = 1'b0;

  assign receiveMode     = state_ff.mode != ocpll_pkg::ST_USER;
  assign oscOutPowerDown = state_ff.osc_out_power_down;
  assign synthAPowerDown = state_ff.aPd;
  assign synthBPowerDown = state_ff.bPd;
  // oscillator reference offered while either synthesiser is powered up or in receive mode
  assign oscRefEnable    = !state_ff.aPd || !state_ff.bPd
                           || receiveMode;

  // synthesiser A: receiver owns multipliers and divider mode in receive
  always_comb
  begin
    if (receiveMode)
    begin
      synthA.fracMult    = state_ff.frozenFrac;
      synthA.intMult     = state_ff.frozenInt;
      synthA.outDivMode  = RX_CORE_MODE;
      synthA.outDivExtra = state_ff.aExtra;
      synthA.inputDiv    = state_ff.aInDiv;
    end
    else
    begin
      synthA.fracMult    = state_ff.aFrac;
      synthA.intMult     = state_ff.aInt;
      synthA.outDivMode  = state_ff.aMode;
      synthA.outDivExtra = state_ff.aExtra;
      synthA.inputDiv    = state_ff.aInDiv;
    end
  end

  // synthesiser B always follows software; it is the reference in receive
  assign synthB.fracMult    = state_ff.bFrac;
  assign synthB.intMult     = state_ff.bInt;
  assign synthB.inputDiv    = state_ff.bInDiv;
  assign synthB.outDivMode  = state_ff.bMode;
  assign synthB.outDivExtra = state_ff.bExtra;

  // A output gated while tracking, first lock or retrack; B output unusable in receive
  assign synthAOutEnable    = !state_ff.aPd
                              && state_ff.mode != ocpll_pkg::ST_TRACK;
  assign synthBOutAvailable = !state_ff.bPd && !receiveMode;

endmodule : ocpll_ctrl

/* ocpll_rx_model.sv */
/* behavioural receiver model: enable, lock, stream and recovered multipliers.
   assumes the bench commands it on sys_clk and the block shares that clock. */
`timescale 1ns/1ns
module ocpll_rx_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        enReq,
  input  wire logic        lockReq,
  input  wire logic        streamReq,
  input  wire logic [21:0] rateFrac,
  output logic             rxEnable,
  output logic             rxLocked,
  output logic             rxStreamPresent,
  output logic [21:0]      rxFracMult,
  output logic [3:0]       rxIntMult
);
  // no stream: multipliers churn every cycle, so a frozen copy shows up
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      {rxEnable, rxLocked, rxStreamPresent} <= 3'h0;
      rxFracMult <= 22'h0;
      rxIntMult  <= 4'h0;
    end
    else
    begin
      rxEnable        <= enReq;  // oscillator stays up meanwhile
      rxStreamPresent <= streamReq;
      rxLocked        <= lockReq & streamReq;
      rxFracMult      <= streamReq ? rateFrac : ~rxFracMult;
      rxIntMult       <= streamReq ? 4'h8 : ~rxIntMult;
    end
  end
endmodule : ocpll_rx_model

/* ocpll_ctrl_asserts.sv */
/* checker for the synthesiser control block, bound to its ports.
   assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ns
module ocpll_ctrl_asserts (
  input wire logic                     sys_clk,
  input wire logic                     rst,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [11:0]              paddr,
  input wire logic [31:0]              pwdata,
  input wire ocpll_pkg::ocpll_apb_rsp_s apbRsp,
  input wire logic                     rxEnable,
  input wire logic                     rxLocked,
  input wire logic                     rxStreamPresent,
  input wire logic [21:0]              rxFracMult,
  input wire logic [3:0]               rxIntMult,
  input wire logic                     oscOutPowerDown,
  input wire logic                     synthAPowerDown,
  input wire logic                     synthBPowerDown,
  input wire ocpll_pkg::ocpll_synth_s  synthA,
  input wire logic                     synthAOutEnable,
  input wire logic                     synthBOutAvailable,
  input wire logic                     receiveMode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // write strobe of the access phase
  logic wrStb;
  assign wrStb = psel && penable && pwrite;

  power_write_a: assert property (wrStb && paddr == 12'h0CC |=>
    oscOutPowerDown == $past(pwdata[0]) && synthAPowerDown == $past(pwdata[1])
    && synthBPowerDown == $past(pwdata[2])) else $error("power bits wrong");
  mode_follow_a: assert property (1'b1 |=>
    receiveMode == $past(rxEnable)) else $error("mode not following enable");
  a_tracks_a: assert property (rxEnable && rxStreamPresent ##1 rxEnable |->
    synthA.fracMult == $past(rxFracMult) && synthA.intMult == $past(rxIntMult))
    else $error("A multipliers not from receiver");
  a_freeze_a: assert property (receiveMode && rxEnable && !rxStreamPresent
    ##1 rxEnable |-> $stable(synthA.fracMult) && $stable(synthA.intMult))
    else $error("A multipliers moved without stream");
  a_stop_a: assert property (rxEnable && rxStreamPresent && !rxLocked
    ##1 rxEnable |-> !synthAOutEnable) else $error("A output ran unlocked");
  a_divmode_a: assert property (receiveMode |-> synthA.outDivMode == 2'h2)
    else $error("A divider mode not fixed");
  b_unavail_a: assert property (receiveMode |-> !synthBOutAvailable)
    else $error("B offered in receive mode");
  a_outen_a: assert property (synthAOutEnable |-> !synthAPowerDown)
    else $error("A output while powered down");
  user_mult_a: assert property (!receiveMode && wrStb && paddr == 12'h008
    ##1 !receiveMode |-> synthA.intMult == $past(pwdata[7:4])
    && synthA.fracMult[21:18] == $past(pwdata[3:0])) else $error("A int wrong");
  apb_ok_a: assert property (apbRsp.pready && !apbRsp.pslverr)
    else $error("bus answer not ready or error");
endmodule : ocpll_ctrl_asserts

bind ocpll_ctrl ocpll_ctrl_asserts ocpll_ctrl_asserts_inst (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .apbRsp(apbRsp),
  .rxEnable(rxEnable), .rxLocked(rxLocked), .rxStreamPresent(rxStreamPresent),
  .rxFracMult(rxFracMult), .rxIntMult(rxIntMult),
  .oscOutPowerDown(oscOutPowerDown), .synthAPowerDown(synthAPowerDown),
  .synthBPowerDown(synthBPowerDown), .synthA(synthA),
  .synthAOutEnable(synthAOutEnable), .synthBOutAvailable(synthBOutAvailable),
  .receiveMode(receiveMode));

/* tb_ocpll_ctrl.sv */
/* self-checking bench: APB master, receiver model, scenario tasks.
   assumes a zero-wait slave and word index = byte address / 4. */
`timescale 1ns/1ns
module tb_ocpll_ctrl;
  logic sys_clk, rst, psel, penable, pwrite, enReq, lockReq, streamReq;
  logic rxEnable, rxLocked, rxStreamPresent, oscOutPowerDown, receiveMode;
  logic oscRefEnable;
  logic synthAPowerDown, synthBPowerDown, synthAOutEnable, synthBOutAvailable;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [21:0] rateFrac, rxFracMult;
  logic [3:0] rxIntMult;
  ocpll_pkg::ocpll_apb_rsp_s apbRsp;
  ocpll_pkg::ocpll_synth_s synthA, synthB;
  int err_total, num_checks, cycles;
  // reset table, element i at slice i
  localparam logic [71:0] IX = 72'h33_07_06_05_04_03_02_01_00;
  localparam logic [80:0] RV = {9'h006, 9'h010, 9'h07D, 9'h17E, 9'h121,
                                9'h010, 9'h07D, 9'h17D, 9'h121};

  ocpll_ctrl ocpll_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .apbRsp(apbRsp), .rxEnable(rxEnable), .rxLocked(rxLocked),
    .rxStreamPresent(rxStreamPresent), .rxFracMult(rxFracMult),
    .rxIntMult(rxIntMult), .oscOutPowerDown(oscOutPowerDown),
    .synthAPowerDown(synthAPowerDown), .synthBPowerDown(synthBPowerDown),
    .synthA(synthA), .synthB(synthB), .synthAOutEnable(synthAOutEnable),
    .synthBOutAvailable(synthBOutAvailable), .receiveMode(receiveMode),
    .oscRefEnable(oscRefEnable));
  ocpll_rx_model ocpll_rx_model_inst (.sys_clk(sys_clk), .rst(rst),
    .enReq(enReq), .lockReq(lockReq), .streamReq(streamReq),
    .rateFrac(rateFrac), .rxEnable(rxEnable), .rxLocked(rxLocked),
    .rxStreamPresent(rxStreamPresent), .rxFracMult(rxFracMult),
    .rxIntMult(rxIntMult));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // one setup plus access; held until pready is seen high
  task xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (apbRsp.pready !== 1'b1) @(posedge sys_clk);
    rd = apbRsp.prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task reset_vals;
    for (int i = 0; i < 9; i++)
    begin
      xfer(1'b0, IX[8*i +: 8], 32'h0);
      chk(rd, {23'h0, RV[9*i +: 9]});
    end
    chk({10'h0, synthA.fracMult}, 32'h36FB21);
    chk({10'h0, synthB.fracMult}, 32'h36FD21);
    chk(oscRefEnable, 32'h0);
  endtask : reset_vals

  // stray upper bits written everywhere except index 01 must vanish
  task user_mode;
    xfer(1'b1, 8'h00, 32'hFFFF_FE55);
    xfer(1'b1, 8'h01, 32'h0000_00AA);
    xfer(1'b1, 8'h02, 32'hFFFF_FF8C);  // int 8, inside five..thirteen
    xfer(1'b1, 8'h03, 32'hFFFF_FFFF);
    xfer(1'b1, 8'h20, 32'hFFFF_FFFF);
    tick(1);
    chk({2'h0, synthA}, {2'h0, 22'h315455, 4'h8, 1'b1, 2'h3, 1'b1});
    xfer(1'b0, 8'h02, 32'h0);
    chk(rd, 32'h8C);
    xfer(1'b0, 8'h03, 32'h0);
    chk(rd, 32'h1B);
    xfer(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
  endtask : user_mode

  task power;
    xfer(1'b1, 8'h33, 32'hFFFF_FFF9);
    tick(1);
    chk({oscOutPowerDown, synthAPowerDown, synthBPowerDown}, 32'h4);
    chk({synthBOutAvailable, synthAOutEnable}, 32'h3);
    chk(oscRefEnable, 32'h1);
    xfer(1'b0, 8'h33, 32'h0);
    chk(rd, 32'h1);
    xfer(1'b1, 8'h33, 32'h0);  // crystal: stage back up
    xfer(1'b1, 8'h03, 32'h2);  // A input div equals B's
  endtask : power

  task receive;
    @(posedge sys_clk);
    rateFrac <= 22'h2ABCDE;
    enReq <= 1'b1;
    streamReq <= 1'b1;
    tick(3);
    chk({receiveMode, synthBOutAvailable, synthAOutEnable}, 32'h4);
    chk({synthA.fracMult, synthA.intMult}, {22'h2ABCDE, 4'h8});
    chk({synthA.outDivMode, synthA.outDivExtra}, 32'h5);
    @(posedge sys_clk);
    lockReq <= 1'b1;
    tick(3);
    chk(synthAOutEnable, 1'b1);
    xfer(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h15);
    @(posedge sys_clk);
    streamReq <= 1'b0;
    tick(4);
    chk({synthA.fracMult, synthAOutEnable}, {22'h2ABCDE, 1'b1});
    @(posedge sys_clk);
    rateFrac <= 22'h1F0F0F;
    lockReq <= 1'b0;
    streamReq <= 1'b1;
    tick(3);
    chk({synthA.fracMult, synthAOutEnable}, {22'h1F0F0F, 1'b0});
    xfer(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h03);
    @(posedge sys_clk);
    enReq <= 1'b0;
    tick(3);
    chk({receiveMode, synthBOutAvailable}, 32'h1);
    chk({10'h0, synthA.fracMult}, 32'h315455);
  endtask : receive

  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test;
    end
  end

  initial
  begin
    {rst, psel, penable, pwrite, enReq, lockReq, streamReq} = 7'h40;
    {paddr, pwdata, rateFrac} = 66'h0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    reset_vals;
    user_mode;
    power;
    receive;
    end_of_test;
  end
endmodule : tb_ocpll_ctrl
